//--- core/sar_adc_cfg.svh
// Offsets, field positions, reset values and timing counts of the converter
`ifndef SAR_ADC_CFG_SVH
`define SAR_ADC_CFG_SVH

////////////////////////////////////////////////////////////////////////////
// Register indices; the byte address is four times the index
`define IDX_CONTROL_1   6'h34
`define IDX_CONTROL_2   6'h35
`define IDX_RESULT_LOW  6'h36
`define IDX_RESULT_HIGH 6'h37
`define CTRL_RESET      8'h00

////////////////////////////////////////////////////////////////////////////
// Field positions
`define C1_START        7
`define C1_MODE_HI      6
`define C1_MODE_LO      5
`define C1_GATE         4
`define C1_CHAN_HI      3
`define C2_DONE         7
`define C2_BUSY         6
`define C2_TSEL_HI      2

////////////////////////////////////////////////////////////////////////////
// Mode and channel codes
`define MODE_OFF        2'h0
`define MODE_SINGLE     2'h1
`define MODE_REPEAT     2'h3
`define CHAN_LAST       4'h7

////////////////////////////////////////////////////////////////////////////
// Timing: conversion times in fcgck cycles, fcgck derived from CLK_SYS
`define CLK_HZ          125000000
`define FCGCK_HZ        2500000
`define TCONV_0         9'h027
`define TCONV_1         9'h04E
`define TCONV_2         9'h09C
`define TCONV_3         9'h138
`define RES_BITS        10
`define BIT_CYC         16'h0008
`define TRIAL_CYC       16'h0050
`define SAR_MSB         10'h200

////////////////////////////////////////////////////////////////////////////
// Bus answers
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

//--- core/sar_adc_pkg.sv
// Types shared by the converter sequencer and its approximation register
package sar_adc_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_TRIAL,
    ST_STORE
  } conv_state_t;

  typedef struct packed {
    logic [9:0] code;
    logic [9:0] mask;
  } sar_state_t;

  typedef struct packed {
    // Software-visible control and status
    logic        start;
    logic [1:0]  mode;
    logic        gate;
    logic [3:0]  chan;
    logic [2:0]  tsel;
    logic        done;
    logic        busy;
    logic        lock;
    logic [9:0]  res;
    // Sequencer
    conv_state_t state;
    logic [15:0] cnt;
    logic [3:0]  bitn;
    // Comparator synchroniser
    logic        cs1;
    logic        cs2;
    logic        cs3;
    logic        cmp;
    // Analog side outputs
    logic        hold;
    logic        ref_en;
    logic [2:0]  chan_out;
    logic [7:0]  an_en;
    logic        irq;
    // Bus slave
    logic        aw_held;
    logic [5:0]  awidx;
    logic        w_held;
    logic [7:0]  wdata;
    logic        wlane;
    logic        awrdy;
    logic        wrdy;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arrdy;
    logic        rvalid;
    logic [7:0]  rdata;
    logic [1:0]  rresp;
  } seq_state_t;

endpackage

//--- core/sar_register.sv
// Ten-bit successive approximation register driving the DA converter code
`timescale 1ns/1ps
`include "sar_adc_cfg.svh"

module sar_register (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  load,
  input  wire logic                  decide,
  input  wire logic                  comp,
  output logic [`RES_BITS-1:0]       code
);

  sar_adc_pkg::sar_state_t q;
  sar_adc_pkg::sar_state_t d;

  always_comb begin
    logic [9:0] c;
    c = q.code;
    d = q;
    if (load) begin
      d.code = `SAR_MSB;
      d.mask = `SAR_MSB;
    end else if (decide) begin
      // Comparator low: input below trial level, drop the bit
      if (!comp) begin
        c = c & ~q.mask;
      end
      c = c | (q.mask >> 1);
      d.code = c;
      d.mask = q.mask >> 1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign code = q.code;

endmodule // sar_register

//--- core/sar_adc_control_sequencer.sv
// Control registers and conversion sequencer of the 10-bit SAR converter
//
// How it works
// RQ1 - Ten-bit result by successive approximation
// RQ2 - Start bit begins conversion, self-clears
// RQ3 - Mode: 00 off, 01 single, 11 repeat
// RQ4 - Gate bit 0 disables all analog inputs
// RQ5 - Channel codes 0-7 select inputs; rest reserved
// RQ6 - Software leaves settings alone while busy
// RQ7 - Low power clears start, mode, gate
// RQ8 - Done flag bit 7 marks ended conversion
// RQ9 - Busy flag bit 6 while converting
// RQ10 - Time select picks 39/78/156/312 fcgck cycles
// RQ11 - Software changes time select only when idle
// RQ12 - Software writes zero to bit 3
// RQ13 - Bits 3 to 5 read zero
// RQ14 - Low power clears done and busy
// RQ15 - High result read or restart clears done
// RQ16 - Start and store latencies within limits
// RQ17 - Software keeps conversion time in range
// RQ18 - Reference current off when not converting
// RQ19 - Completion stores result, sets done, interrupts
// RQ20 - Repeat mode restarts after each completion
// RQ21 - Split result read blocks new result
// RQ22 - Mode 00 stops and clears everything; the code keeps gate, channel and time select
// RQ23 - Counter times conversion; busy until done
`timescale 1ns/1ps
`include "sar_adc_cfg.svh"

module sar_adc_control_sequencer #(
  parameter int FCGCK_DIV = `CLK_HZ / `FCGCK_HZ
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  input  wire logic        LOW_POWER_ENTRY,
  input  wire logic        COMP_IN,
  output logic             SAMPLE_HOLD,
  output logic             REF_CURRENT_EN,
  output logic [2:0]       CHANNEL_SEL,
  output logic [7:0]       ANALOG_EN,
  output logic [9:0]       DAC_CODE,
  output logic             DONE_IRQ
);

  sar_adc_pkg::seq_state_t q;
  sar_adc_pkg::seq_state_t d;

  logic [8:0]  tconv;
  logic [15:0] conv_len;
  logic [15:0] sample_len;
  logic        go;
  logic        again;
  logic        sar_load;
  logic        sar_decide;
  logic [9:0]  sar_code;
  logic [7:0]  rd_word;
  logic        rd_err;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion length in CLK_SYS cycles

  always_comb begin
    case (q.tsel)
      3'h0:    tconv = `TCONV_0; // RQ10
      3'h1:    tconv = `TCONV_1; // RQ10
      3'h2:    tconv = `TCONV_2; // RQ10
      3'h3:    tconv = `TCONV_3; // RQ10
      // Reserved codes fall back to the longest time
      default: tconv = `TCONV_3;
    endcase
  end

  assign conv_len   = 16'(32'(tconv) * FCGCK_DIV);

  // Sampling takes what the ten bit trials leave over; a divider too
  // small for the trials clamps it rather than wrap the counter
  always_comb begin
    if (conv_len > `TRIAL_CYC) begin
      sample_len = conv_len - `TRIAL_CYC - 16'h0001;
    end else begin
      sample_len = 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer controls

  assign go = (q.state == sar_adc_pkg::ST_IDLE) && q.start &&
              ((q.mode == `MODE_SINGLE) || (q.mode == `MODE_REPEAT));
  assign again = (q.state == sar_adc_pkg::ST_STORE) &&
                 (q.mode == `MODE_REPEAT);
  assign sar_load   = go || again;
  assign sar_decide = (q.state == sar_adc_pkg::ST_TRIAL) &&
                      (q.cnt == 16'h0000);

  ////////////////////////////////////////////////////////////////////////////
  // Approximation register

  sar_register u_sar (
    .clk    (CLK_SYS),
    .rst_n  (RST_N),
    .load   (sar_load),
    .decide (sar_decide),
    .comp   (q.cmp),
    .code   (sar_code)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read data for the address on offer

  always_comb begin
    rd_word = 8'h00;
    rd_err  = 1'b0;
    case (ARADDR[7:2])
      `IDX_CONTROL_1: begin
        rd_word = {q.start, q.mode, q.gate, q.chan};
      end
      `IDX_CONTROL_2: begin
        rd_word = {q.done, q.busy, 3'h0, q.tsel}; // RQ8 RQ9 RQ13
      end
      `IDX_RESULT_LOW: begin
        rd_word = q.res[7:0];
      end
      `IDX_RESULT_HIGH: begin
        rd_word = {6'h00, q.res[9:8]};
      end
      default: begin
        rd_err = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d = q;
    d.irq = 1'b0;

    // Comparator sync: a change counts once stages two and three agree
    d.cs1 = COMP_IN;
    d.cs2 = q.cs1;
    d.cs3 = q.cs2;
    if (q.cs2 == q.cs3) begin
      d.cmp = q.cs3;
    end

    // Write address and data taken in either order
    if (AWVALID && q.awrdy) begin
      d.aw_held = 1'b1;
      d.awidx   = AWADDR[7:2];
    end
    if (WVALID && q.wrdy) begin
      d.w_held = 1'b1;
      d.wdata  = WDATA[7:0];
      d.wlane  = WSTRB[0];
    end
    if (q.bvalid && BREADY) begin
      d.bvalid = 1'b0;
    end

    if (q.aw_held && q.w_held && !q.bvalid) begin
      d.aw_held = 1'b0;
      d.w_held  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = `RESP_OKAY;
      case (q.awidx)
        `IDX_CONTROL_1: begin
          if (q.wlane) begin
            // Writing zero to the start bit leaves a pending start
            if (q.wdata[`C1_START]) begin
              d.start = 1'b1; // RQ2
            end
            d.mode = q.wdata[`C1_MODE_HI:`C1_MODE_LO]; // RQ3
            d.gate = q.wdata[`C1_GATE];
            d.chan = q.wdata[`C1_CHAN_HI:0];
          end
        end
        `IDX_CONTROL_2: begin
          // Only the time select is stored; bit 3 is dropped
          if (q.wlane) begin
            d.tsel = q.wdata[`C2_TSEL_HI:0]; // RQ12
          end
        end
        `IDX_RESULT_LOW, `IDX_RESULT_HIGH: begin
        end
        default: d.bresp = `RESP_SLVERR;
      endcase
    end

    // Reads, with their side effects on the result handshake
    if (q.rvalid && RREADY) begin
      d.rvalid = 1'b0;
    end
    if (ARVALID && q.arrdy) begin
      d.rvalid = 1'b1;
      d.rdata  = rd_word;
      d.rresp  = rd_err ? `RESP_SLVERR : `RESP_OKAY;
      if (ARADDR[7:2] == `IDX_RESULT_LOW) begin
        d.lock = 1'b1; // RQ21
      end
      if (ARADDR[7:2] == `IDX_RESULT_HIGH) begin
        d.lock = 1'b0; // RQ21
        d.done = 1'b0; // RQ15
      end
    end

    // Conversion sequencer
    case (q.state)
      sar_adc_pkg::ST_IDLE: begin
        if (go) begin
          d.start  = 1'b0; // RQ2
          d.done   = 1'b0; // RQ15
          d.busy   = 1'b1; // RQ9 RQ23
          d.hold   = 1'b1;
          d.ref_en = 1'b1; // RQ18
          d.cnt    = sample_len; // RQ16
          d.state  = sar_adc_pkg::ST_SAMPLE;
        end else if (q.start && (q.mode != `MODE_SINGLE) &&
                     (q.mode != `MODE_REPEAT)) begin
          // Start in a reserved mode is dropped
          d.start = 1'b0;
        end
      end
      sar_adc_pkg::ST_SAMPLE: begin
        if (q.cnt == 16'h0000) begin
          d.hold  = 1'b0;
          d.cnt   = `BIT_CYC - 16'h0001;
          d.bitn  = 4'(`RES_BITS - 1);
          d.state = sar_adc_pkg::ST_TRIAL;
        end else begin
          d.cnt = q.cnt - 16'h0001; // RQ23
        end
      end
      sar_adc_pkg::ST_TRIAL: begin
        if (q.cnt != 16'h0000) begin
          d.cnt = q.cnt - 16'h0001; // RQ23
        end else if (q.bitn == 4'h0) begin
          d.state = sar_adc_pkg::ST_STORE; // RQ1
        end else begin
          d.bitn = q.bitn - 4'h1; // RQ1
          d.cnt  = `BIT_CYC - 16'h0001;
        end
      end
      sar_adc_pkg::ST_STORE: begin
        // A split result read keeps the old value and stays silent;
        // a low read in this very cycle counts as one, else halves tear
        if (!d.lock) begin // RQ21
          d.res  = sar_code; // RQ19
          d.done = 1'b1; // RQ19
          d.irq  = 1'b1; // RQ19
        end
        if (again) begin
          d.hold  = 1'b1; // RQ20
          d.cnt   = sample_len;
          d.state = sar_adc_pkg::ST_SAMPLE;
        end else begin
          d.busy   = 1'b0; // RQ9 RQ23
          d.ref_en = 1'b0; // RQ18
          d.state  = sar_adc_pkg::ST_IDLE;
        end
      end
      default: d.state = sar_adc_pkg::ST_IDLE;
    endcase

    // Entry to a low-power mode drops the setup
    if (LOW_POWER_ENTRY) begin
      d.start = 1'b0; // RQ7
      d.mode  = `MODE_OFF; // RQ7
      d.gate  = 1'b0; // RQ7
      d.done  = 1'b0; // RQ14
      d.busy  = 1'b0; // RQ14
    end

    // Mode off stops at once, storing nothing
    if (d.mode == `MODE_OFF) begin
      d.state  = sar_adc_pkg::ST_IDLE; // RQ3 RQ22
      d.start  = 1'b0;
      d.done   = 1'b0; // RQ22
      d.busy   = 1'b0; // RQ22
      d.res    = 10'h000; // RQ22
      d.lock   = 1'b0;
      d.irq    = 1'b0;
      d.hold   = 1'b0;
      d.ref_en = 1'b0; // RQ18
    end

    // Analog input routing follows the next control values
    d.chan_out = d.chan[2:0];
    d.an_en    = 8'h00;
    if (d.gate && (d.chan <= `CHAN_LAST)) begin // RQ4 RQ5
      d.an_en = 8'h01 << d.chan[2:0]; // RQ5
    end

    // One request of each kind in flight; ready drops while one is held
    d.awrdy = !d.aw_held;
    d.wrdy  = !d.w_held;
    d.arrdy = !d.rvalid;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      q       <= '0;
      q.state <= sar_adc_pkg::ST_IDLE;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign AWREADY        = q.awrdy;
  assign WREADY         = q.wrdy;
  assign BVALID         = q.bvalid;
  assign BRESP          = q.bresp;
  assign ARREADY        = q.arrdy;
  assign RVALID         = q.rvalid;
  assign RRESP          = q.rresp;
  assign RDATA          = {24'h000000, q.rdata};
  assign SAMPLE_HOLD    = q.hold;
  assign REF_CURRENT_EN = q.ref_en;
  assign CHANNEL_SEL    = q.chan_out;
  assign ANALOG_EN      = q.an_en;
  assign DAC_CODE       = sar_code;
  assign DONE_IRQ       = q.irq;

endmodule // sar_adc_control_sequencer

//--- tb/sar_comparator_model.sv
// Ideal comparator and DA converter standing in for the analog core
`timescale 1ns/1ps
module sar_comparator_model (
  input  wire logic [9:0] dac_code,
  input  wire logic [9:0] level,
  output logic            comp
);
  // Input at or above trial code keeps the bit; no noise or offset modelled
  assign comp = (level >= dac_code);
endmodule // sar_comparator_model

//--- tb/sar_adc_asserts.sv
// Port-level assertions on the converter sequencer
`timescale 1ns/1ps
`include "sar_adc_cfg.svh"
module sar_adc_asserts (
  input wire logic        CLK_SYS,
  input wire logic        RST_N,
  input wire logic [7:0]  AWADDR,
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0]  WSTRB,
  input wire logic        WVALID,
  input wire logic        WREADY,
  input wire logic        BVALID,
  input wire logic [7:0]  ARADDR,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic        RVALID,
  input wire logic        LOW_POWER_ENTRY,
  input wire logic        SAMPLE_HOLD,
  input wire logic        REF_CURRENT_EN,
  input wire logic [2:0]  CHANNEL_SEL,
  input wire logic [7:0]  ANALOG_EN,
  input wire logic        DONE_IRQ
);
  localparam logic [7:0] A_C1 = 8'(`IDX_CONTROL_1 * 4);
  localparam logic [7:0] A_C2 = 8'(`IDX_CONTROL_2 * 4);
  logic [7:0] tri_cnt_q;
  logic [7:0] ar_q;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////
  // Cycles since sampling ended; saturates so aborted runs stay quiet
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N || SAMPLE_HOLD) begin
      tri_cnt_q <= 8'h00;
    end else if (tri_cnt_q != 8'hFF) begin
      tri_cnt_q <= tri_cnt_q + 8'h01;
    end
    if (!RST_N) begin
      ar_q <= 8'h00;
    end else if (ARVALID && ARREADY) begin
      ar_q <= ARADDR;
    end
  end
  sequence s_wr_both;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  sequence s_start;
    s_wr_both ##0 (WSTRB[0] && AWADDR == A_C1 && WDATA[7]
      && WDATA[6:5] == `MODE_SINGLE && !REF_CURRENT_EN);
  endsequence
  ////////////////////////////////////////
  AST_IRQ_PULSE: assert property (DONE_IRQ |=> !DONE_IRQ)
    else $error("done pulse too long");
  AST_IRQ_TRIALS: assert property (DONE_IRQ |->
    tri_cnt_q >= 8'h4E && tri_cnt_q <= 8'h54)
    else $error("done not after ten trials");
  AST_HOLD_REF: assert property (SAMPLE_HOLD |-> REF_CURRENT_EN)
    else $error("sampling without reference");
  AST_CHAN_ONEHOT: assert property (ANALOG_EN != 8'h00 |->
    ANALOG_EN == (8'h01 << CHANNEL_SEL))
    else $error("analog enable not matching channel");
  AST_START_LAT: assert property (s_start |->
    ##[1:10] REF_CURRENT_EN)
    else $error("start latency too long");
  AST_LP_CLEAR: assert property (LOW_POWER_ENTRY |-> ##2
    (!REF_CURRENT_EN && !SAMPLE_HOLD && ANALOG_EN == 8'h00))
    else $error("low power left converter active");
  AST_B_LAT: assert property (s_wr_both |-> ##2 BVALID)
    else $error("write response late");
  AST_AR_LAT: assert property (ARVALID && ARREADY |=>
    RVALID && !ARREADY)
    else $error("read answer late");
  AST_RD_CTRL2: assert property (RVALID && ar_q == A_C2 |->
    RDATA[5:3] == 3'h0 && RDATA[31:8] == 24'h000000)
    else $error("status reserved bits set");
endmodule // sar_adc_asserts

bind sar_adc_control_sequencer sar_adc_asserts chk (.CLK_SYS, .RST_N,
  .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BVALID,
  .ARADDR, .ARVALID, .ARREADY, .RDATA, .RVALID, .LOW_POWER_ENTRY,
  .SAMPLE_HOLD, .REF_CURRENT_EN, .CHANNEL_SEL, .ANALOG_EN, .DONE_IRQ);

//--- tb/test_sar_adc_control_sequencer.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`include "sar_adc_cfg.svh"
module test_sar_adc_control_sequencer;
  // Time limits bind the analog core; the ideal comparator has none,
  // so a short divider keeps the run brief for every time code
  localparam int DIV = 3;
  localparam logic [7:0] A_C1 = 8'(`IDX_CONTROL_1 * 4);
  localparam logic [7:0] A_C2 = 8'(`IDX_CONTROL_2 * 4);
  localparam logic [7:0] A_RL = 8'(`IDX_RESULT_LOW * 4);
  localparam logic [7:0] A_RH = 8'(`IDX_RESULT_HIGH * 4);
  localparam logic [1:0] OK = `RESP_OKAY;
  logic        CLK_SYS, RST_N, AWVALID, AWREADY, WVALID, WREADY, BVALID;
  logic        BREADY, ARVALID, ARREADY, RVALID, RREADY, LOW_POWER_ENTRY;
  logic        COMP_IN, SAMPLE_HOLD, REF_CURRENT_EN, DONE_IRQ;
  logic [7:0]  AWADDR, ARADDR, ANALOG_EN;
  logic [31:0] WDATA, RDATA;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP;
  logic [2:0]  CHANNEL_SEL;
  logic [9:0]  DAC_CODE, level;
  int          num_errors = 0, check_count = 0, cycles = 0;
  int          ref_run = 0, ref_last = 0, tcs[4] = '{39, 78, 156, 312};

  sar_adc_control_sequencer #(.FCGCK_DIV(DIV)) dut (.CLK_SYS, .RST_N,
    .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP,
    .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID,
    .RREADY, .LOW_POWER_ENTRY, .COMP_IN, .SAMPLE_HOLD, .REF_CURRENT_EN,
    .CHANNEL_SEL, .ANALOG_EN, .DAC_CODE, .DONE_IRQ);
  sar_comparator_model model (.dac_code(DAC_CODE), .level(level),
    .comp(COMP_IN));

  initial begin
    CLK_SYS = 1'b0;
    forever #4 CLK_SYS = ~CLK_SYS;
  end
  ////////////////////////////////////////
  // Length of each reference-current burst, kept for the single scenario
  always @(posedge CLK_SYS) begin
    cycles <= cycles + 1;
    if (REF_CURRENT_EN) begin
      ref_run <= ref_run + 1;
    end else if (ref_run != 0) begin
      ref_last <= ref_run;
      ref_run <= 0;
    end
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic check(input logic [31:0] got, exp, input string msg);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask
  ////////////////////////////////////////
  // Bus master; BREADY and RREADY stay high, which the bus allows
  task automatic wchk(input logic [7:0] a, d, input logic [1:0] er);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    AWADDR <= a;
    WDATA <= {24'h000000, d};
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    while (!(aw && w)) begin
      @(posedge CLK_SYS);
      if (!aw && AWREADY) begin
        aw = 1'b1;
        AWVALID <= 1'b0;
      end
      if (!w && WREADY) begin
        w = 1'b1;
        WVALID <= 1'b0;
      end
    end
    do @(posedge CLK_SYS); while (!BVALID);
    check(32'(BRESP), 32'(er), "write response");
  endtask
  task automatic rchk(input logic [7:0] a, ed, input logic [1:0] er);
    ARADDR <= a;
    ARVALID <= 1'b1;
    do @(posedge CLK_SYS); while (!ARREADY);
    ARVALID <= 1'b0;
    do @(posedge CLK_SYS); while (!RVALID);
    check(RDATA, {24'h000000, ed}, "read data");
    check(32'(RRESP), 32'(er), "read response");
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (DONE_IRQ !== 1'b1 && n < 1200) begin
      @(posedge CLK_SYS);
      n++;
    end
    check(32'(DONE_IRQ), 32'h1, "no done pulse");
    tick(1);
  endtask
  ////////////////////////////////////////
  task automatic t_regs();
    rchk(A_C1, 8'h00, OK);
    rchk(A_C2, 8'h00, OK);
    wchk(A_C2, 8'h32, OK);
    rchk(A_C2, 8'h02, OK);
    WSTRB <= 4'hE;
    wchk(A_C2, 8'h05, OK);
    WSTRB <= 4'hF;
    rchk(A_C2, 8'h02, OK);
    wchk(A_C1, 8'h47, OK);
    tick(2);
    rchk(A_C1, 8'h47, OK);
    check(32'(ANALOG_EN), 32'h0, "gate off");
    check(32'(CHANNEL_SEL), 32'h7, "channel");
    wchk(A_C1, 8'h1C, OK);
    tick(2);
    check(32'(ANALOG_EN), 32'h0, "reserved channel");
    wchk(A_C1, 8'h17, OK);
    tick(2);
    check(32'(ANALOG_EN), 32'h80, "channel seven");
    wchk(A_C1, 8'h00, OK);
    wchk(A_RL, 8'hFF, OK);
    rchk(A_RL, 8'h00, OK);
    wchk(8'h10, 8'h00, `RESP_SLVERR);
    rchk(8'h10, 8'h00, `RESP_SLVERR);
    $display("registers scenario ended");
  endtask
  task automatic t_single(input logic [2:0] ts, input logic [3:0] ch,
                          input logic [9:0] v);
    int tc;
    tc = tcs[ts[1:0]] * DIV;
    level <= v;
    wchk(A_C2, {5'h00, ts}, OK);
    wchk(A_C1, 8'hB0 | {4'h0, ch}, OK);
    rchk(A_C1, 8'h30 | {4'h0, ch}, OK);
    rchk(A_C2, 8'h40 | {5'h00, ts}, OK);
    check(32'(ANALOG_EN), 32'h1 << ch, "enable");
    while (REF_CURRENT_EN) @(posedge CLK_SYS);
    tick(2);
    check(32'(ref_last >= tc && ref_last <= tc + 2), 32'h1, "time");
    rchk(A_C2, 8'h80 | {5'h00, ts}, OK);
    rchk(A_RL, v[7:0], OK);
    rchk(A_RH, {6'h00, v[9:8]}, OK);
    rchk(A_C2, {5'h00, ts}, OK);
    $display("single scenario ended");
  endtask
  task automatic t_repeat();
    int n;
    level <= 10'h155;
    wchk(A_C2, 8'h00, OK);
    wchk(A_C1, 8'hF5, OK);
    wait_irq();
    wait_irq();
    rchk(A_C2, 8'hC0, OK);
    check(32'(ANALOG_EN), 32'h20, "repeat channel");
    rchk(A_RL, 8'h55, OK);
    level <= 10'h2AA;
    n = 0;
    repeat (300) begin
      @(posedge CLK_SYS);
      n += int'(DONE_IRQ === 1'b1);
    end
    check(32'(n), 32'h0, "pulse while locked");
    rchk(A_RH, 8'h01, OK);
    wait_irq();
    rchk(A_RL, 8'hAA, OK);
    rchk(A_RH, 8'h02, OK);
    tick(20);
    // Only a mode 00 write is legal while busy
    wchk(A_C1, 8'h15, OK);
    rchk(A_C2, 8'h00, OK);
    rchk(A_RL, 8'h00, OK);
    rchk(A_RH, 8'h00, OK);
    check(32'(REF_CURRENT_EN), 32'h0, "reference on");
    $display("repeat scenario ended");
  endtask
  task automatic t_lowpower();
    level <= 10'h0F0;
    wchk(A_C2, 8'h01, OK);
    wchk(A_C1, 8'hB2, OK);
    wait_irq();
    tick(2);
    rchk(A_C2, 8'h81, OK);
    wchk(A_C1, 8'hB2, OK);
    rchk(A_C2, 8'h41, OK);
    tick(30);
    LOW_POWER_ENTRY <= 1'b1;
    tick(1);
    LOW_POWER_ENTRY <= 1'b0;
    tick(2);
    rchk(A_C1, 8'h02, OK);
    rchk(A_C2, 8'h01, OK);
    check(32'(REF_CURRENT_EN), 32'h0, "reference on");
    check(32'(ANALOG_EN), 32'h0, "inputs on");
    $display("low power scenario ended");
  endtask
  ////////////////////////////////////////
  initial begin
    RST_N = 1'b0;
    {AWVALID, WVALID, ARVALID, LOW_POWER_ENTRY} = 4'h0;
    {BREADY, RREADY} = 2'h3;
    {AWADDR, ARADDR} = 16'h0000;
    WDATA = 32'h00000000;
    WSTRB = 4'hF;
    level = 10'h000;
    tick(6);
    RST_N <= 1'b1;
    tick(3);
    t_regs();
    t_single(3'h0, 4'h3, 10'h2C5);
    t_single(3'h1, 4'h0, 10'h3FF);
    t_single(3'h2, 4'h7, 10'h000);
    t_single(3'h3, 4'h5, 10'h155);
    t_repeat();
    t_lowpower();
    final_report();
  end
endmodule // test_sar_adc_control_sequencer
